/* hdl/sram_host.sv */
`timescale 1ns/1ns
module sram_host #(
  parameter int ADDR_W = sram_host_pkg::ADDR_W,
  parameter int DATA_W = sram_host_pkg::DATA_W
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  // user request
  input wire logic REQ_VALID_I,
  input wire logic REQ_WRITE_I,
  input wire logic [ADDR_W-1:0] REQ_ADDR_I,
  input wire logic [DATA_W-1:0] REQ_WDATA_I,
  output logic REQ_READY_O,
  // user answer
  output logic RSP_VALID_O,
  output logic [DATA_W-1:0] RSP_RDATA_O,
  // memory pins
  output logic CHIP_SELECT_ACTIVE_LOW_O,
  output logic CHIP_SELECT_ACTIVE_HIGH_O,
  output logic WE_N_O,
  output logic OE_N_O,
  output logic [ADDR_W-1:0] ADDR_O,
  input wire logic [DATA_W-1:0] DQ_I,
  output logic [DATA_W-1:0] DQ_O,
  output logic DQ_OE_N_O
);

  typedef enum logic [4:0] {
    IDLE = 5'b00001,
    READ = 5'b00010,
    WSTROBE = 5'b00100,
    WEND = 5'b01000,
    FLOAT = 5'b10000
  } state_e;

  state_e state;
  sram_host_pkg::req_s req;
  sram_host_pkg::strobe_s pins;
  logic [DATA_W-1:0] dq_meta;
  logic [DATA_W-1:0] dq_sync;
  logic load;
  logic [sram_host_pkg::CNT_W-1:0] load_count;
  logic done;
  logic take;

  assign take = REQ_VALID_I && REQ_READY_O;

  sram_cycle_timer #(
    .CNT_W(sram_host_pkg::CNT_W)
  ) u_timer (
    .clk_i(CLK_I),
    .arst_n_i(ARST_N_I),
    .load_i(load),
    .count_i(load_count),
    .done_o(done)
  );

  // timer loads on entry to READ, WSTROBE, WEND and FLOAT, not on return to IDLE
  always_comb
  begin
    load = 1'b0;
    load_count = 4'h0;
    unique case (state)
      IDLE:
      begin
        load = take;
        load_count = REQ_WRITE_I ? 4'(sram_host_pkg::WR_CYC - 1)
          : 4'(sram_host_pkg::RD_CYC - 1);
      end
      READ:
      begin
        load = done;
        load_count = 4'(sram_host_pkg::FLOAT_CYC);
      end
      WSTROBE:
      begin
        load = done;
        load_count = 4'h0;
      end
      WEND, FLOAT: ;
    endcase
  end

  // sequencing
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      state <= IDLE;
    else
      unique case (state)
        IDLE:
          if (take)
            state <= REQ_WRITE_I ? WSTROBE : READ;
        READ:
          if (done)
            state <= FLOAT;
        WSTROBE:
          if (done)
            state <= WEND;
        WEND:
          state <= IDLE;
        FLOAT:
          if (done)
            state <= IDLE;
      endcase
  end

  // latched request, address and data stay through the write end
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      req <= '0;
    else if (take)
      req <= '{REQ_WRITE_I, REQ_ADDR_I, REQ_WDATA_I};
  end

  // select and strobe pins, all driven to hard levels
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      pins <= sram_host_pkg::STROBE_IDLE;
    else
    begin
      pins <= sram_host_pkg::STROBE_IDLE;
      if (state == IDLE && take)
      begin
        pins.chip_select_active_low <= 1'b0;
        pins.chip_select_active_high <= 1'b1;
        pins.we_n <= !REQ_WRITE_I;
        pins.oe_n <= REQ_WRITE_I;
      end
      else if (state == READ && !done)
      begin
        pins.chip_select_active_low <= 1'b0;
        pins.chip_select_active_high <= 1'b1;
        pins.oe_n <= 1'b0;
      end
      else if (state == WSTROBE && !done)
      begin
        pins.chip_select_active_low <= 1'b0;
        pins.chip_select_active_high <= 1'b1;
        pins.we_n <= 1'b0;
      end
      // write strobe ends alone; selects drop the next cycle, avoiding a blip
      else if (state == WSTROBE && done)
      begin
        pins.chip_select_active_low <= 1'b0;
        pins.chip_select_active_high <= 1'b1;
      end
    end
  end

  // address pins
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      ADDR_O <= '0;
    else if (take)
      ADDR_O <= REQ_ADDR_I;
  end

  // data pins: driven only in the write phases, a cycle after the gate rises
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      DQ_O <= '0;
      DQ_OE_N_O <= 1'b1;
    end
    else
    begin
      DQ_O <= req.wdata;
      DQ_OE_N_O <= !((state == WSTROBE) || (state == WEND && !done));
    end
  end

  // read data crosses in from the pins through two flops
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      dq_meta <= '0;
      dq_sync <= '0;
    end
    else
    begin
      dq_meta <= DQ_I;
      dq_sync <= dq_meta;
    end
  end

  // answer: one pulse per request
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      RSP_VALID_O <= 1'b0;
      RSP_RDATA_O <= '0;
    end
    else
    begin
      RSP_VALID_O <= (state == READ && done) || (state == WEND);
      if (state == READ && done)
        RSP_RDATA_O <= dq_sync;
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      REQ_READY_O <= 1'b0;
    else
      REQ_READY_O <= (state == IDLE && !take) || (state == WEND)
        || (state == FLOAT && done);
  end

  assign CHIP_SELECT_ACTIVE_LOW_O = pins.chip_select_active_low;
  assign CHIP_SELECT_ACTIVE_HIGH_O = pins.chip_select_active_high;
  assign WE_N_O = pins.we_n;
  assign OE_N_O = pins.oe_n;

endmodule

/* hdl/sram_host_pkg.sv */
package sram_host_pkg;

  localparam int ADDR_W = 18;
  localparam int DATA_W = 8;

  // timing figures in ns, clock period in ns
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_RC_NS = 45;
  localparam int T_WC_NS = 45;
  localparam int T_PWE_NS = 35;
  localparam int STROBE_TO_FLOAT_DELAY_NS = 18;
  localparam int DATA_SETUP_BEFORE_WRITE_END_NS = 25;
  localparam int T_HZOE_NS = 18;
  localparam int T_HZCE_NS = 18;

  // least times round up
  localparam int RD_CYC = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int PWE_MIN_NS = (T_PWE_NS > STROBE_TO_FLOAT_DELAY_NS
    + DATA_SETUP_BEFORE_WRITE_END_NS) ? T_PWE_NS
    : STROBE_TO_FLOAT_DELAY_NS + DATA_SETUP_BEFORE_WRITE_END_NS;
  localparam int WR_CYC = (PWE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_CYC = ((T_HZOE_NS > T_HZCE_NS ? T_HZOE_NS : T_HZCE_NS)
    + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } req_s;

  typedef struct packed {
    logic chip_select_active_low;
    logic chip_select_active_high;
    logic we_n;
    logic oe_n;
  } strobe_s;

  localparam strobe_s STROBE_IDLE = '{1'b1, 1'b0, 1'b1, 1'b1};

endpackage

/* hdl/sram_cycle_timer.sv */
`timescale 1ns/1ns
module sram_cycle_timer #(
  parameter int CNT_W = 4
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic load_i,
  input wire logic [CNT_W-1:0] count_i,
  output logic done_o
);
  logic [CNT_W-1:0] remain;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      remain <= '0;
    else if (load_i)
      remain <= count_i;
    else if (remain != '0)
      remain <= remain - CNT_W'(1);
  end

  // no path from load back to done: the caller loads on done
  assign done_o = (remain == '0);
endmodule

/* sim/sram_mem_model.sv */
`timescale 1ns/1ns
module sram_mem_model (
  // strobes
  input wire logic cs_n_i,
  input wire logic cs_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  // address and data
  input wire logic [17:0] addr_i,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o
);
  logic [7:0] mem [262144];
  logic [7:0] last = 8'h00;
  wire sel = !cs_n_i && cs_i;
  // write opens on overlap of all three, lands on whichever edge ends it
  wire wr_on = sel && !we_n_i;
  always @(negedge wr_on)
    mem[addr_i] = dq_i;
  // floating bus shows no stale byte
  always @*
    if (sel && we_n_i && !oe_n_i)
    begin
      dq_o = mem[addr_i];
      last = dq_o;
    end
    else
      dq_o = ~last;
endmodule

/* sim/sram_host_checker.sv */
`timescale 1ns/1ns
module sram_host_checker (
  // clock and reset
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  // user side
  input wire logic REQ_VALID_I,
  input wire logic REQ_WRITE_I,
  input wire logic REQ_READY_O,
  input wire logic RSP_VALID_O,
  // memory pins
  input wire logic CHIP_SELECT_ACTIVE_LOW_O,
  input wire logic CHIP_SELECT_ACTIVE_HIGH_O,
  input wire logic WE_N_O,
  input wire logic OE_N_O,
  input wire logic DQ_OE_N_O
);
  default clocking @(posedge CLK_I);
  endclocking
  default disable iff (!ARST_N_I);
  sequence take_s;
    REQ_VALID_I && REQ_READY_O;
  endsequence
  // write ends by strobe, answer and data release follow a cycle later
  sequence wr_end_s;
    (WE_N_O && !DQ_OE_N_O && !CHIP_SELECT_ACTIVE_LOW_O) ##1 (RSP_VALID_O && DQ_OE_N_O);
  endsequence
  a_sel_levels: assert property (CHIP_SELECT_ACTIVE_LOW_O == !CHIP_SELECT_ACTIVE_HIGH_O)
    else $error("selects not complementary");
  a_no_bus_fight: assert property (!OE_N_O |-> DQ_OE_N_O)
    else $error("host drives data during read");
  a_we_pulse_len: assert property ($fell(WE_N_O) |-> !WE_N_O [*3])
    else $error("write strobe too short");
  a_data_setup: assert property ($rose(WE_N_O) |-> $past(!DQ_OE_N_O, 2))
    else $error("data not set up before write end");
  a_write_walk: assert property (take_s ##0 REQ_WRITE_I |-> ##1 !WE_N_O [*3] ##1 wr_end_s)
    else $error("write sequence wrong");
  a_read_walk: assert property (take_s ##0 !REQ_WRITE_I |-> ##2 !OE_N_O [*3] ##1 RSP_VALID_O)
    else $error("read sequence wrong");
  a_busy_refuse: assert property (take_s |=> !REQ_READY_O)
    else $error("ready while busy");
  a_rsp_pulse: assert property (RSP_VALID_O |=> !RSP_VALID_O)
    else $error("answer longer than one cycle");
endmodule
bind sram_host sram_host_checker chk_u (.CLK_I, .ARST_N_I, .REQ_VALID_I, .REQ_WRITE_I,
  .REQ_READY_O, .RSP_VALID_O, .CHIP_SELECT_ACTIVE_LOW_O, .CHIP_SELECT_ACTIVE_HIGH_O,
  .WE_N_O, .OE_N_O, .DQ_OE_N_O);

/* sim/tb_top.sv */
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic vld = 1'b0;
  logic wr = 1'b0;
  logic [17:0] adr = 18'h00000;
  logic [7:0] wd = 8'h00;
  logic rdy, rv, csl, csh, we_n, oe_n, dq_oe_n;
  logic [7:0] rd, dq_h, dq_m;
  logic [17:0] madr;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  wire [7:0] dq = dq_oe_n ? dq_m : dq_h;
  sram_host dut_u (.CLK_I(clk), .ARST_N_I(arst_n), .REQ_VALID_I(vld), .REQ_WRITE_I(wr),
    .REQ_ADDR_I(adr), .REQ_WDATA_I(wd), .REQ_READY_O(rdy), .RSP_VALID_O(rv),
    .RSP_RDATA_O(rd), .CHIP_SELECT_ACTIVE_LOW_O(csl), .CHIP_SELECT_ACTIVE_HIGH_O(csh),
    .WE_N_O(we_n), .OE_N_O(oe_n), .ADDR_O(madr), .DQ_I(dq), .DQ_O(dq_h),
    .DQ_OE_N_O(dq_oe_n));
  sram_mem_model mem_u (.cs_n_i(csl), .cs_i(csh), .we_n_i(we_n), .oe_n_i(oe_n),
    .addr_i(madr), .dq_i(dq), .dq_o(dq_m));
  initial
    forever #10 clk = ~clk;
  // both sides driving the data bus at once
  always @(posedge clk)
  begin
    cyc++;
    if (!csl && csh && we_n && !oe_n)
      `CHK(dq_oe_n, 1'b1)
    if (cyc == 3000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic op(input logic w, input logic [17:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    vld <= 1'b1;
    wr <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (!rdy && ++n < 20);
    vld <= 1'b0;
    do @(posedge clk); while (!rv && ++n < 40);
    `CHK(rv, 1'b1)
  endtask
  task automatic t_idle();
    `CHK({csl, csh, we_n, oe_n, dq_oe_n}, 5'h17)
  endtask
  // address extremes catch dropped or swapped address bits
  task automatic t_wr_rd();
    logic [17:0] a [3] = '{18'h00000, 18'h3ffff, 18'h12345};
    foreach (a[i])
      op(1'b1, a[i], 8'h5a ^ i[7:0]);
    foreach (a[i])
    begin
      op(1'b0, a[i], 8'h00);
      `CHK(rd, 8'h5a ^ i[7:0])
      `CHK(mem_u.mem[a[i]], 8'h5a ^ i[7:0])
    end
  endtask
  task automatic t_overwrite();
    op(1'b1, 18'h00001, 8'h11);
    op(1'b1, 18'h00001, 8'h22);
    `CHK(mem_u.mem[1], 8'h22)
    op(1'b0, 18'h00001, 8'h00);
    `CHK(rd, 8'h22)
  endtask
  task automatic report_and_stop();
    $display("errors %0d tests %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    t_idle();
    arst_n <= 1'b1;
    t_wr_rd();
    t_overwrite();
    report_and_stop();
  end
endmodule
